// ==== stxw_write_port.sv ====
// Transmit buffer write port, partition pointers and serviced-port status
// Summary of operation
// - end flag moves partition to next line
// - write enable high captures data word
// - each write stores its port number
// - line terminate advances addressed partition line
// - link disable stops all partition reads
// - disabled link sends idle, fill still counts
// - write side runs on own clock only
// - full reported for selected partition address
// - full high once fill reaches threshold
// - serviced id is real or user port
// - flow status aligned with serviced id
// - burst output gives serviced cycle count
// - each serviced cycle attempts one line read
// - reference clock at quarter link rate
// - alignment select chooses status sample point
// - up to eight partitions, shared by ports
// - no byte enables drops the write
module stxw_write_port #(
	parameter int unsigned PART_LINES = stxw_pkg::PART_LINES,
	parameter int unsigned LINE_AW    = 2
) (
	// Write clock domain
	input  wire logic                                 clk,
	input  wire logic                                 reset_n,
	input  wire logic                                 clk_en,
	// User write interface
	input  wire logic                                 tx_wr_enable,
	input  wire logic [stxw_pkg::DATA_W-1:0]          tx_wr_data,
	input  wire logic [stxw_pkg::BE_W-1:0]            tx_wr_byte_enables,
	input  wire logic [stxw_pkg::PART_SEL_W-1:0]      tx_partition_select,
	input  wire logic [stxw_pkg::PORT_W-1:0]          tx_wr_port_number,
	input  wire logic                                 tx_wr_start_of_packet,
	input  wire logic                                 tx_wr_end_of_packet,
	input  wire logic                                 tx_wr_packet_error,
	input  wire logic                                 tx_wr_line_terminate,
	input  wire logic                                 tx_wr_link_disable,
	input  wire logic [LINE_AW:0]                     fill_threshold,
	output logic                                      tx_partition_full,
	// Scheduler side, sampled on link clock edges
	input  wire logic                                 incoming_link_clock,
	input  wire logic                                 sched_load,
	input  wire logic [stxw_pkg::PART_SEL_W-1:0]      sched_partition,
	input  wire logic [stxw_pkg::PORT_W-1:0]          sched_link_port,
	input  wire logic [stxw_pkg::PORT_W-1:0]          sched_user_port,
	input  wire logic                                 port_id_user_mode,
	input  wire logic [stxw_pkg::STAT_W-1:0]          sched_flow_status,
	input  wire logic [stxw_pkg::BURST_W-1:0]         sched_burst,
	// Serviced port status
	output logic      [stxw_pkg::PORT_W-1:0]          serviced_port_id,
	output logic      [stxw_pkg::STAT_W-1:0]          serviced_port_flow_status,
	output logic      [stxw_pkg::BURST_W-1:0]         serviced_burst_cycles,
	// Line read toward the link
	output logic                                      line_rd_valid,
	output logic      [stxw_pkg::LINE_W-1:0]          line_rd_data,
	output logic      [stxw_pkg::PORT_W-1:0]          line_rd_port,
	output logic                                      line_rd_sop,
	output logic                                      line_rd_eop,
	output logic                                      line_rd_err,
	output logic                                      link_tx_idle,
	// Clocks and status alignment
	output logic                                      tx_quarter_ref_clock,
	input  wire logic                                 incoming_status_clock,
	input  wire logic                                 status_clock_align_select,
	output logic                                      status_sample_strobe
);
	localparam int unsigned NP    = stxw_pkg::NUM_PARTS;
	localparam int unsigned DEPTH = NP * PART_LINES;
	localparam int unsigned AW    = stxw_pkg::PART_SEL_W + LINE_AW;
	localparam logic [LINE_AW:0] ONE_LINE = (LINE_AW+1)'(1);
	localparam logic [LINE_AW:0] ALL_LINES = (LINE_AW+1)'(PART_LINES);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [stxw_pkg::SYNC_STAGES-1:0] lclk_sync_q;
	logic [stxw_pkg::SYNC_STAGES-1:0] sclk_sync_q;
	logic                             lclk_prev_q;
	logic                             sclk_prev_q;
	logic                             lclk_rise;
	logic                             sclk_rise;

	// Second and third stages feed the agreement check, never the first
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lclk_sync_q <= '0;
			sclk_sync_q <= '0;
			lclk_prev_q <= 1'b0;
			sclk_prev_q <= 1'b0;
		end else if (clk_en) begin
			lclk_sync_q <= {lclk_sync_q[1:0], incoming_link_clock};
			sclk_sync_q <= {sclk_sync_q[1:0], incoming_status_clock};
			if (lclk_sync_q[1] == lclk_sync_q[2]) lclk_prev_q <= lclk_sync_q[2];
			if (sclk_sync_q[1] == sclk_sync_q[2]) sclk_prev_q <= sclk_sync_q[2];
		end
	end
	assign lclk_rise = clk_en && (lclk_sync_q[1] == lclk_sync_q[2]) && lclk_sync_q[2]
		&& !lclk_prev_q;
	assign sclk_rise = clk_en && (sclk_sync_q[1] == sclk_sync_q[2]) && sclk_sync_q[2]
		&& !sclk_prev_q;

	// ----------------------------------------
	// Write side decode
	// ----------------------------------------
	logic [stxw_pkg::WORD_IDX_W-1:0] word_q [NP];
	logic [LINE_AW-1:0]              wr_line_q [NP];
	logic [LINE_AW-1:0]              rd_line_q [NP];
	logic [LINE_AW:0]                fill_q [NP];
	logic [NP-1:0]                   adv;
	logic [NP-1:0]                   pop;
	logic                            room;
	logic                            accept;
	logic                            rd_fire;
	logic [stxw_pkg::PART_SEL_W-1:0] rd_part_q;
	logic [stxw_pkg::WORD_IDX_W-1:0] sel_word;

	assign sel_word = word_q[tx_partition_select];
	assign room     = fill_q[tx_partition_select] != ALL_LINES;
	// Writes with no byte enable are dropped outright
	assign accept   = clk_en && tx_wr_enable && (|tx_wr_byte_enables) && room;

	// ----------------------------------------
	// Per-partition pointers and fill
	// ----------------------------------------
	for (genvar p = 0; p < NP; p++) begin : g_part
		logic hit;
		assign hit    = tx_partition_select == stxw_pkg::PART_SEL_W'(p);
		// A line closes on its last word, an end flag or a forced terminate
		assign adv[p] = hit && ((accept && (word_q[p] == stxw_pkg::LAST_WORD
			|| tx_wr_end_of_packet)) || (clk_en && tx_wr_line_terminate && room));
		assign pop[p] = rd_fire && rd_part_q == stxw_pkg::PART_SEL_W'(p);

		always_ff @(posedge clk or negedge reset_n) begin
			if (!reset_n) begin
				word_q[p]    <= '0;
				wr_line_q[p] <= '0;
				rd_line_q[p] <= '0;
				fill_q[p]    <= '0;
			end else if (clk_en) begin
				if (adv[p]) begin
					word_q[p]    <= '0;
					wr_line_q[p] <= wr_line_q[p] + 1'b1;
				end else if (hit && accept) begin
					word_q[p] <= word_q[p] + 1'b1;
				end
				if (pop[p]) rd_line_q[p] <= rd_line_q[p] + 1'b1;
				// Fill keeps counting while the link is disabled
				fill_q[p] <= fill_q[p] + (adv[p] ? ONE_LINE : '0) - (pop[p] ? ONE_LINE : '0);
			end
		end
	end

	// Full follows the selected partition, registered on the write clock
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_partition_full <= 1'b0;
		end else if (clk_en) begin
			tx_partition_full <= fill_q[tx_partition_select] >= fill_threshold;
		end
	end

	// ----------------------------------------
	// Line memory and per-line tags
	// ----------------------------------------
	logic [AW-1:0]                   wr_addr;
	logic [AW-1:0]                   rd_addr;
	logic [stxw_pkg::LINE_BE_W-1:0]  wr_be;
	logic [stxw_pkg::PORT_W-1:0]     tag_port [DEPTH];
	logic [DEPTH-1:0]                tag_sop;
	logic [DEPTH-1:0]                tag_eop;
	logic [DEPTH-1:0]                tag_err;

	assign wr_addr = {tx_partition_select, wr_line_q[tx_partition_select]};
	assign rd_addr = {rd_part_q, rd_line_q[rd_part_q]};
	assign wr_be   = stxw_pkg::LINE_BE_W'(tx_wr_byte_enables) << (4 * sel_word);

	stxw_line_ram #(
		.DEPTH  (DEPTH),
		.ADDR_W (AW)
	) u_ram (
		.clk     (clk),
		.clk_en  (clk_en),
		.wr_en   (accept),
		.wr_addr (wr_addr),
		.wr_be   (wr_be),
		.wr_line ({stxw_pkg::WORDS_PER_LINE{tx_wr_data}}),
		.rd_en   (rd_fire),
		.rd_addr (rd_addr),
		.rd_line (line_rd_data)
	);

	// Tags are rewritten on each word; only the first word writes the start flag
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tag_sop <= '0;
			tag_eop <= '0;
			tag_err <= '0;
		end else if (accept) begin
			if (sel_word == '0) tag_sop[wr_addr] <= tx_wr_start_of_packet;
			tag_eop[wr_addr] <= tx_wr_end_of_packet;
			tag_err[wr_addr] <= tx_wr_packet_error && tx_wr_end_of_packet;
		end
	end

	always_ff @(posedge clk) begin
		if (accept) tag_port[wr_addr] <= tx_wr_port_number;
	end

	// ----------------------------------------
	// Serviced port and burst
	// ----------------------------------------
	logic [stxw_pkg::BURST_W-1:0] burst_left_q;
	logic                         attempt;

	// One attempt per link cycle while burst remains; disable stops them
	assign attempt = lclk_rise && burst_left_q != '0 && !tx_wr_link_disable;
	assign rd_fire = attempt && fill_q[rd_part_q] != '0;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_part_q                 <= '0;
			burst_left_q              <= stxw_pkg::BURST_RST;
			serviced_port_id          <= stxw_pkg::PORT_RST;
			serviced_port_flow_status <= stxw_pkg::STAT_RST;
			serviced_burst_cycles     <= stxw_pkg::BURST_RST;
		end else if (lclk_rise) begin
			if (sched_load && (burst_left_q == '0 || tx_wr_link_disable)) begin
				rd_part_q                 <= sched_partition;
				burst_left_q              <= sched_burst;
				serviced_burst_cycles     <= sched_burst;
				serviced_port_flow_status <= sched_flow_status;
				serviced_port_id <= port_id_user_mode ? sched_user_port : sched_link_port;
			end else if (attempt) begin
				burst_left_q <= burst_left_q - 1'b1;
			end
		end
	end

	// Read results line up with the registered memory output
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			line_rd_valid <= 1'b0;
			line_rd_port  <= stxw_pkg::PORT_RST;
			line_rd_sop   <= 1'b0;
			line_rd_eop   <= 1'b0;
			line_rd_err   <= 1'b0;
			link_tx_idle  <= 1'b1;
		end else if (clk_en) begin
			line_rd_valid <= rd_fire;
			if (lclk_rise) link_tx_idle <= !rd_fire;
			if (rd_fire) begin
				line_rd_port <= tag_port[rd_addr];
				line_rd_sop  <= tag_sop[rd_addr];
				line_rd_eop  <= tag_eop[rd_addr];
				line_rd_err  <= tag_err[rd_addr];
			end
		end
	end

	// ----------------------------------------
	// Quarter-rate reference and status sampling
	// ----------------------------------------
	logic [0:0] qcnt_q;
	logic       sclk_late_q;

	// Toggle every second link edge: four link periods per output period
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			qcnt_q               <= '0;
			tx_quarter_ref_clock <= 1'b0;
		end else if (lclk_rise) begin
			qcnt_q <= qcnt_q + 1'b1;
			if (qcnt_q == stxw_pkg::QCLK_EDGES) tx_quarter_ref_clock <= !tx_quarter_ref_clock;
		end
	end

	// Edge-aligned status clock is sampled one cycle late to sit mid-eye
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sclk_late_q          <= 1'b0;
			status_sample_strobe <= 1'b0;
		end else if (clk_en) begin
			sclk_late_q          <= sclk_rise;
			status_sample_strobe <= status_clock_align_select ? sclk_rise : sclk_late_q;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_NO_READ_WHILE_DISABLED: assert property (@(posedge clk) disable iff (!reset_n)
		tx_wr_link_disable |-> !rd_fire) else $error("line read while link disabled");
	AST_IDLE_WHEN_DISABLED: assert property (@(posedge clk) disable iff (!reset_n)
		lclk_rise && tx_wr_link_disable |=> link_tx_idle) else $error("link not idle");
	AST_EOP_ADVANCES: assert property (@(posedge clk) disable iff (!reset_n)
		accept && tx_wr_end_of_packet |=> sel_word == '0 || $past(tx_partition_select)
		!= tx_partition_select) else $error("end flag did not close line");
	AST_NO_BE_NO_WRITE: assert property (@(posedge clk) disable iff (!reset_n)
		tx_wr_enable && tx_wr_byte_enables == '0 && !tx_wr_line_terminate
		|=> $stable(sel_word) || $changed(tx_partition_select)) else $error("empty write kept");
	AST_TERM_ADVANCES: assert property (@(posedge clk) disable iff (!reset_n)
		clk_en && tx_wr_line_terminate && room
		|=> sel_word == '0 || $changed(tx_partition_select)) else $error("terminate ignored");
	AST_FULL_TRACKS: assert property (@(posedge clk) disable iff (!reset_n)
		clk_en && $stable(tx_partition_select) && fill_q[tx_partition_select] >= fill_threshold
		|=> tx_partition_full || !clk_en) else $error("full missing");
	AST_READ_ONE_LINE: assert property (@(posedge clk) disable iff (!reset_n)
		rd_fire |=> line_rd_valid ##1 !line_rd_valid || $past(rd_fire))
		else $error("read not single line");
	AST_BURST_COUNTS: assert property (@(posedge clk) disable iff (!reset_n)
		attempt && !sched_load |=> burst_left_q == $past(burst_left_q) - 1'b1)
		else $error("burst not counted");
	AST_QCLK_SLOW: assert property (@(posedge clk) disable iff (!reset_n)
		$changed(tx_quarter_ref_clock) |-> qcnt_q == '0) else $error("quarter clock off");
	AST_STRB_ALIGN: assert property (@(posedge clk) disable iff (!reset_n)
		clk_en && sclk_rise && status_clock_align_select |=> status_sample_strobe)
		else $error("status strobe late");
endmodule

// ==== stxw_pkg.sv ====
// Shared constants for the transmit buffer write port
package stxw_pkg;
	// ----------------------------------------
	// Write interface geometry
	// ----------------------------------------
	localparam int unsigned NUM_PARTS      = 8;
	localparam int unsigned PART_SEL_W     = 3;
	localparam int unsigned DATA_W         = 32;
	localparam int unsigned BE_W           = 4;
	localparam int unsigned WORDS_PER_LINE = 4;
	localparam int unsigned WORD_IDX_W     = 2;
	localparam int unsigned LINE_W         = 128;
	localparam int unsigned LINE_BE_W      = 16;
	localparam int unsigned PORT_W         = 8;
	localparam int unsigned STAT_W         = 2;
	localparam int unsigned BURST_W        = 4;
	localparam int unsigned PART_LINES     = 4;

	// ----------------------------------------
	// Field positions, reset values, timing
	// ----------------------------------------
	localparam logic [WORD_IDX_W-1:0] LAST_WORD     = 2'h3;
	localparam logic [PORT_W-1:0]     PORT_RST      = 8'h00;
	localparam logic [STAT_W-1:0]     STAT_RST      = 2'h0;
	localparam logic [BURST_W-1:0]    BURST_RST     = 4'h0;
	localparam int unsigned           SYNC_STAGES   = 3;
	localparam logic [0:0]            QCLK_EDGES    = 1'h1; // link edges per half period, less one
endpackage

// ==== stxw_line_ram.sv ====
// Dual-port line memory with per-byte write enables
module stxw_line_ram #(
	parameter int unsigned DEPTH  = 32,
	parameter int unsigned ADDR_W = 5
) (
	// Clock
	input  wire logic                                clk,
	input  wire logic                                clk_en,
	// Write port
	input  wire logic                                wr_en,
	input  wire logic [ADDR_W-1:0]                   wr_addr,
	input  wire logic [stxw_pkg::LINE_BE_W-1:0]      wr_be,
	input  wire logic [stxw_pkg::LINE_W-1:0]         wr_line,
	// Read port
	input  wire logic                                rd_en,
	input  wire logic [ADDR_W-1:0]                   rd_addr,
	output logic      [stxw_pkg::LINE_W-1:0]         rd_line
);
	// ----------------------------------------
	// Byte lanes
	// ----------------------------------------
	// Each lane owns its storage, so one process drives it and dropped bytes keep old contents
	for (genvar b = 0; b < stxw_pkg::LINE_BE_W; b++) begin : g_lane
		logic [7:0] lane_q [DEPTH];

		always_ff @(posedge clk) begin
			if (clk_en && wr_en && wr_be[b]) begin
				lane_q[wr_addr] <= wr_line[8*b +: 8];
			end
		end

		// Registered read, no reset on memory data path
		always_ff @(posedge clk) begin
			if (clk_en && rd_en) begin
				rd_line[8*b +: 8] <= lane_q[rd_addr];
			end
		end
	end
endmodule

// ==== stxw_user_writer.sv ====
// Model of the user logic that writes packet words into the transmit buffer
module stxw_user_writer (
	// Clock
	input  wire logic                       clk,
	// Write interface toward the buffer
	output logic                            tx_wr_enable,
	output logic [stxw_pkg::DATA_W-1:0]     tx_wr_data,
	output logic [stxw_pkg::BE_W-1:0]       tx_wr_byte_enables,
	output logic [stxw_pkg::PART_SEL_W-1:0] tx_partition_select,
	output logic [stxw_pkg::PORT_W-1:0]     tx_wr_port_number,
	output logic                            tx_wr_start_of_packet,
	output logic                            tx_wr_end_of_packet,
	output logic                            tx_wr_packet_error,
	output logic                            tx_wr_line_terminate
);
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------
	// Idle levels and bus release
	// ----------------------------------------
	// Released data, port and byte-enable lines show the inverse; control lines go low
	task automatic let_go();
		tx_wr_enable = 1'b0;
		tx_wr_start_of_packet = 1'b0;
		tx_wr_end_of_packet = 1'b0;
		tx_wr_packet_error = 1'b0;
		tx_wr_line_terminate = 1'b0;
		tx_wr_data = ~tx_wr_data;
		tx_wr_port_number = ~tx_wr_port_number;
		tx_wr_byte_enables = ~tx_wr_byte_enables;
	endtask

	initial begin
		tx_wr_data = '0;
		tx_wr_port_number = '0;
		tx_wr_byte_enables = '0;
		tx_partition_select = '0;
		let_go();
	end

	// ----------------------------------------
	// Line writes; mode 1 holds enable low, mode 2 clears byte enables
	// ----------------------------------------
	task automatic put_line(input logic [2:0] part, input logic [7:0] port,
		input logic [31:0] base, input int nw, input logic eop, input logic err,
		input logic [1:0] mode);
		for (int i = 0; i < nw; i++) begin
			@(negedge clk);
			tx_partition_select = part;
			tx_wr_port_number = port;
			tx_wr_data = base + 32'(i);
			tx_wr_enable = (mode != 2'h1);
			tx_wr_byte_enables = (mode == 2'h2) ? 4'h0 : 4'hf;
			tx_wr_start_of_packet = (i == 0);
			tx_wr_end_of_packet = eop && (i == nw - 1);
			tx_wr_packet_error = err && eop && (i == nw - 1);
		end
		@(negedge clk);
		let_go();
	endtask

	// Line close without data, then partition choice for the full status
	task automatic terminate(input logic [2:0] part);
		@(negedge clk);
		tx_partition_select = part;
		tx_wr_line_terminate = 1'b1;
		@(negedge clk);
		tx_wr_line_terminate = 1'b0;
	endtask

	task automatic pick(input logic [2:0] part);
		@(negedge clk);
		tx_partition_select = part;
	endtask
endmodule

// ==== test_spi4_tx_fifo_write_port.sv ====
// Self-checking bench for the transmit buffer write port
module test_spi4_tx_fifo_write_port;
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic         clk, reset_n, link_clk, status_clk, align_sel, link_dis, load, umode, en;
	logic         we, sop, eop, err, term, full, rd_v, rd_sop, rd_eop, rd_err, idle, qclk, stb;
	logic [2:0]   thr, sel, spart, p;
	logic [7:0]   lport, uport, wport, id, rd_port;
	logic [7:0]   pt[4];
	logic [31:0]  wdata;
	logic [31:0]  base[4];
	logic [3:0]   be, bst, burst_o;
	logic [1:0]   flow, stat;
	logic [127:0] rd_data;
	logic [127:0] q_data[$];
	logic [10:0]  q_tag[$];
	int           n_fail, checks, cyc, n;
	int           lat[2];

	stxw_user_writer writer (
		.clk(clk), .tx_wr_enable(we), .tx_wr_data(wdata), .tx_wr_byte_enables(be),
		.tx_partition_select(sel), .tx_wr_port_number(wport), .tx_wr_start_of_packet(sop),
		.tx_wr_end_of_packet(eop), .tx_wr_packet_error(err), .tx_wr_line_terminate(term)
	);

	stxw_write_port dut (
		.clk(clk), .reset_n(reset_n), .clk_en(en), .tx_wr_enable(we), .tx_wr_data(wdata),
		.tx_wr_byte_enables(be), .tx_partition_select(sel), .tx_wr_port_number(wport),
		.tx_wr_start_of_packet(sop), .tx_wr_end_of_packet(eop), .tx_wr_packet_error(err),
		.tx_wr_line_terminate(term), .tx_wr_link_disable(link_dis), .fill_threshold(thr),
		.tx_partition_full(full), .incoming_link_clock(link_clk), .sched_load(load),
		.sched_partition(spart), .sched_link_port(lport), .sched_user_port(uport),
		.port_id_user_mode(umode), .sched_flow_status(flow), .sched_burst(bst),
		.serviced_port_id(id), .serviced_port_flow_status(stat),
		.serviced_burst_cycles(burst_o), .line_rd_valid(rd_v), .line_rd_data(rd_data),
		.line_rd_port(rd_port), .line_rd_sop(rd_sop), .line_rd_eop(rd_eop),
		.line_rd_err(rd_err), .link_tx_idle(idle), .tx_quarter_ref_clock(qclk),
		.incoming_status_clock(status_clk), .status_clock_align_select(align_sel),
		.status_sample_strobe(stb)
	);

	// ----------------------------------------
	// Clocks, read capture and hang guard
	// ----------------------------------------
	always #5 clk = ~clk;

	// Link clock offset so its edges never line up with the write clock
	initial begin
		link_clk = 1'b0;
		#3.3;
		forever #62.5 link_clk = ~link_clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (rd_v === 1'b1) begin
			q_data.push_back(rd_data);
			q_tag.push_back({rd_port, rd_sop, rd_eop, rd_err});
		end
		if (cyc == 30000) begin
			n_fail++;
			results();
		end
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [127:0] line_of(input logic [31:0] b);
		return {b + 32'h3, b + 32'h2, b + 32'h1, b};
	endfunction

	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		if (n_fail == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	task automatic full_is(input logic [2:0] part, input logic exp);
		writer.pick(part);
		repeat (3) @(negedge clk);
		check(full, exp);
	endtask

	// Fields held well clear of link edges so the synchroniser sees them settled
	task automatic sched(input logic [2:0] part, input logic [3:0] nb, input logic mode);
		@(posedge link_clk);
		repeat (6) @(negedge clk);
		spart = part;
		bst = nb;
		umode = mode;
		lport = 8'($urandom);
		uport = 8'($urandom);
		flow = 2'($urandom);
		load = 1'b1;
		@(posedge link_clk);
		repeat (6) @(negedge clk);
		load = 1'b0;
		check(id, mode ? uport : lport);
		check(stat, flow);
		check(burst_o, nb);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		reset_n = 1'b0;
		en = 1'b1;
		{status_clk, align_sel, link_dis, load, umode, spart, bst, lport, uport, flow} = '0;
		thr = 3'h1;
		void'($urandom(32'hf0ada8fe));
		p = 3'($urandom);
		repeat (16) @(negedge clk);
		reset_n = 1'b1;
		check({idle, rd_v, full, id, stat, burst_o, qclk}, {1'b1, 17'h0});
		// Bare line close, full per selected partition
		writer.terminate(p ^ 3'h1);
		full_is(p ^ 3'h1, 1'b1);
		full_is(p, 1'b0);
		// Link disabled: no reads, idle sent, filling still reported
		thr = 3'h2;
		full_is(p ^ 3'h1, 1'b0);
		link_dis = 1'b1;
		sched(p ^ 3'h1, 4'h1, 1'b1);
		writer.put_line(p ^ 3'h1, 8'h3c, 32'($urandom), 4, 1'b0, 1'b0, 2'h0);
		full_is(p ^ 3'h1, 1'b1);
		repeat (40) @(negedge clk);
		check(q_data.size(), 0);
		check(idle, 1'b1);
		link_dis = 1'b0;
		repeat (80) @(negedge clk);
		q_data.delete();
		q_tag.delete();
		// Writes without enable or byte lanes leave the partition empty
		thr = 3'h1;
		writer.put_line(p, 8'h11, 32'($urandom), 4, 1'b0, 1'b0, 2'h1);
		writer.put_line(p, 8'h11, 32'($urandom), 4, 1'b0, 1'b0, 2'h2);
		full_is(p, 1'b0);
		thr = 3'h3;
		for (int i = 0; i < 4; i++) begin
			base[i] = $urandom;
			pt[i] = 8'($urandom);
		end
		for (int i = 0; i < 3; i++) begin
			writer.put_line(p, pt[i], base[i], 4, i == 2, i == 2, 2'h0);
			full_is(p, i == 2);
		end
		writer.put_line(p, pt[3], base[3], 1, 1'b1, 1'b0, 2'h0);
		// Partition now holds four lines: close and write are both refused
		writer.terminate(p);
		writer.put_line(p, 8'h5a, 32'h0, 4, 1'b0, 1'b0, 2'h0);
		full_is(p ^ 3'h1, 1'b0);
		sched(p, 4'h6, 1'b0);
		repeat (130) @(negedge clk);
		check(q_data.size(), 4);
		for (int i = 0; i < 3; i++) begin
			check(q_data[i], line_of(base[i]));
			check(q_tag[i], {pt[i], 1'b1, i == 2, i == 2});
		end
		check(q_data[3][31:0], base[3]);
		check(q_tag[3], {pt[3], 3'h6});
		full_is(p, 1'b0);
		// Quarter-rate reference: four link periods, fifty write clocks
		@(posedge qclk);
		n = cyc;
		@(posedge qclk);
		check((cyc - n) inside {[49:51]}, 1'b1);
		// Status sample point moves by one clock with the alignment select
		for (int s = 0; s < 2; s++) begin
			align_sel = s[0];
			@(negedge clk);
			status_clk = 1'b1;
			n = 0;
			// Looked at between edges, where the strobe has settled
			while (n < 20 && stb !== 1'b1) begin
				@(negedge clk);
				n++;
			end
			lat[s] = n;
			repeat (5) @(negedge clk);
			status_clk = 1'b0;
			repeat (5) @(negedge clk);
		end
		check(lat[0] - lat[1], 1);
		// Frozen clock enable drops a line close on an empty partition
		thr = 3'h1;
		en = 1'b0;
		writer.terminate(p);
		en = 1'b1;
		full_is(p, 1'b0);
		// Every one of the eight partitions takes a line
		for (int k = 0; k < 8; k++) begin
			writer.terminate(3'(k));
			full_is(3'(k), 1'b1);
		end
		results();
	end
endmodule
